// >>> drsc_pkg.sv
// constants, types and register map of the dpll reference and state control block
package drsc_pkg;
  localparam int AW = 8;

  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic          awvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          bready;
    logic [AW-1:0] araddr;
    logic          arvalid;
    logic          rready;
  } drsc_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } drsc_axil_rsp_t;

  typedef enum logic [1:0] {
    ST_FREERUN = 2'b00,
    ST_HOLD    = 2'b01,
    ST_TRACK   = 2'b10,
    ST_NCO     = 2'b11
  } drsc_state_t;

  localparam logic [AW-1:0] OFS_REF_SELECT_CONTROL = 8'h00;
  localparam logic [AW-1:0] OFS_INPUT_PRIORITY_REG = 8'h04;
  localparam logic [AW-1:0] OFS_MISC_CONTROL_TWO   = 8'h08;
  localparam logic [AW-1:0] OFS_PRIORITY_TABLE_TOP = 8'h0c;
  localparam logic [AW-1:0] OFS_PLL_CONTROL_ONE    = 8'h10;
  localparam logic [AW-1:0] OFS_PLL_STATE_STATUS   = 8'h14;
  localparam logic [AW-1:0] OFS_PLL_STATE_STATUS2  = 8'h18;
  localparam logic [AW-1:0] OFS_TRACK_RANGE        = 8'h1c;
  localparam logic [AW-1:0] OFS_PHASE_LOCK_TIMEOUT = 8'h20;
  localparam logic [AW-1:0] OFS_INPUT_STATUS       = 8'h24;
  localparam logic [AW-1:0] OFS_FREQUENCY_REPORT   = 8'h28;
  localparam logic [AW-1:0] OFS_PHASE_REPORT       = 8'h2c;
  localparam logic [AW-1:0] OFS_NCO_WORD_LO        = 8'h30;
  localparam logic [AW-1:0] OFS_NCO_WORD_HI        = 8'h34;
  localparam logic [AW-1:0] OFS_NOMINAL_LO         = 8'h38;
  localparam logic [AW-1:0] OFS_NOMINAL_HI         = 8'h3c;

  localparam logic [1:0]  MODE_AUTO       = 2'h0;
  localparam logic [1:0]  MODE_FORCE_OPEN = 2'h1;
  localparam logic [1:0]  MODE_NCO        = 2'h2;
  localparam logic [1:0]  REF_NONE        = 2'h0;
  localparam logic [1:0]  REF_ONE         = 2'h1;
  localparam logic [1:0]  REF_TWO         = 2'h2;
  localparam logic [1:0]  REF_THREE       = 2'h3;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  localparam logic [11:0] PRIO_RST        = 12'h321;
  localparam logic [3:0]  PRIO_OFF        = 4'h0;
  localparam logic [9:0]  RANGE_MIN_PPM   = 10'h001;
  localparam logic [9:0]  RANGE_MAX_PPM   = 10'h3e8;
  // frequency offsets are signed counts of 0.001 ppb
  localparam logic [31:0] UNITS_PER_PPM   = 32'h000f4240;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          MS_NS           = 1000000;
  localparam int          TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [39:0] NOMINAL_DEF     = 40'h8000000000;
endpackage : drsc_pkg

// >>> drsc_dpll_ctrl.sv
// reference selection, dpll state control, reporting and nco word for the dpll
//
// Notes on behaviour
// - pin switch enable hands selection to pin
// - pin high: clock one, else three
// - pin low: clock two, valid or not
// - switch pin chosen by select field
// - plain 2:1 mux, revertive ignored
// - top valid reference keeps automatic result
// - tracking flag set; loss of lock shown
// - no valid input: open loop, holdover flag
// - freerun zero offset; hold keeps locked offset
// - auto return to tracking; holdover behaviour
// - mode field forces freerun or hold
// - range 1 to 1000 ppm, limit flag
// - hold-in range equals tracking range
// - phase lock criteria, optional frequency criterion
// - lock timeout invalidates input, sets flag
// - frequency and phase reported live
// - nco mode follows 40-bit word
// - nominal word readable, zero offset
// - automatic highest-priority valid selection
// - priority zero disabled, one highest
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module drsc_dpll_ctrl
  import drsc_pkg::*;
#(
  parameter int          TICK_CYCLES = TICK_CYCLES_DEF, // cycles per timeout millisecond
  parameter logic [39:0] NOMINAL     = NOMINAL_DEF      // nominal nco word
) (
  input  wire logic           ref_clk_i,       // master clock
  input  wire logic           sys_rst_i,       // sync reset, active high
  input  wire drsc_axil_req_t axi_i,           // axi4-lite from master
  output drsc_axil_rsp_t      axi_o,           // axi4-lite to master
  input  wire logic [2:0]     ref_valid_i,     // monitor verdict per input
  input  wire logic [3:0]     gpio_i,          // general-purpose pins
  input  wire logic           loop_phase_ok_i, // phase within lock criteria
  input  wire logic [31:0]    loop_ffo_i,      // loop offset, signed
  input  wire logic [31:0]    loop_phase_i,    // phase vs input
  output logic [1:0]          sel_ref_o,       // selected reference
  output logic                open_loop_o,     // not tracking: freerun, hold or nco
  output logic                nco_mode_o,      // nco mode active
  output logic [31:0]         dco_ffo_o,       // offset steering oscillator
  output logic [39:0]         nco_word_o       // applied nco word
);
  logic [3:0]  gpio_m, gpio_s;
  logic        pin_sw_en, revertive_enable_en, freq_crit, hold_beh;
  logic [11:0] prio;
  logic [1:0]  sw_pin_sel, mode, sel, next_sel, top_ref, b_rsp, r_rsp;
  logic [9:0]  range_ppm;
  logic [15:0] lk_timeout, to_cnt;
  logic [2:0]  lock_timeout_flag, avail, lock_timeout_flag_set, lock_timeout_flag_clr;
  logic        tracking, loss_of_lock_flag, holdover, range_lim, hold_ok, pin_lvl, sel_ok;
  logic [31:0] hold_ffo, ffo_clamp, phase_rep, lim, tick_cnt;
  logic        at_limit, ms_tick, to_hit;
  logic [31:0] stage_lo;
  logic [7:0]  stage_hi;
  logic [1:0]  nco_pend;
  drsc_state_t state, next_state;
  logic          aw_full, w_full, do_write, b_vld, r_vld;
  logic [AW-1:0] aw_addr;
  logic [31:0]   w_data, rd_data, r_dat;
  logic [3:0]    w_strb;
  logic          rd_ok;

  function automatic logic [31:0] wr32(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : wr32

  function automatic logic [1:0] best_ref(input logic [11:0] pr, input logic [2:0] av);
    logic [1:0] b;
    logic [3:0] bp;
    b = REF_NONE;
    bp = 4'hf;
    for (int i = 0; i < 3; i++) begin
      if (av[i] && pr[4*i +: 4] != PRIO_OFF && (b == REF_NONE || pr[4*i +: 4] < bp)) begin
        b = 2'(i + 1);
        bp = pr[4*i +: 4];
      end
    end
    return b;
  endfunction : best_ref

  // pins are asynchronous to the master clock
  always_ff @(posedge ref_clk_i) begin
    gpio_m <= gpio_i;
    gpio_s <= gpio_m;
  end

  assign pin_lvl = gpio_s[sw_pin_sel];
  assign avail   = ref_valid_i & ~lock_timeout_flag;
  assign top_ref = best_ref(prio, avail);
  assign sel_ok  = sel != REF_NONE && avail[sel - 2'h1] && prio[4*(sel - 2'h1) +: 4] != PRIO_OFF;

  always_comb begin
    next_sel = sel;
    if (pin_sw_en) begin
      if (pin_lvl) begin
        next_sel = (prio[3:0] != PRIO_OFF) ? REF_ONE : REF_THREE;
      end else begin
        next_sel = REF_TWO;
      end
    end else if (revertive_enable_en || !sel_ok) begin
      next_sel = top_ref;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sel <= REF_NONE;
    end else begin
      sel <= next_sel;
    end
  end

  always_comb begin
    if (mode == MODE_NCO) begin
      next_state = ST_NCO;
    end else if (mode == MODE_FORCE_OPEN || (!pin_sw_en && top_ref == REF_NONE)) begin
      next_state = (hold_ok && !hold_beh) ? ST_HOLD : ST_FREERUN;
    end else begin
      next_state = ST_TRACK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_FREERUN;
    end else begin
      state <= next_state;
    end
  end

  // tracking range is also the hold-in range
  assign lim = {22'h0, range_ppm} * UNITS_PER_PPM;

  always_comb begin
    ffo_clamp = loop_ffo_i;
    at_limit  = 1'b0;
    if ($signed(loop_ffo_i) >= $signed(lim)) begin
      ffo_clamp = lim;
      at_limit  = 1'b1;
    end else if ($signed(loop_ffo_i) <= -$signed(lim)) begin
      ffo_clamp = 32'(-$signed(lim));
      at_limit  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      loss_of_lock_flag       <= 1'b1;
      range_lim <= 1'b0;
      tracking  <= 1'b0;
      holdover  <= 1'b0;
    end else begin
      loss_of_lock_flag       <= state != ST_TRACK || !loop_phase_ok_i || (freq_crit && at_limit);
      range_lim <= state == ST_TRACK && at_limit;
      tracking  <= state == ST_TRACK;
      holdover  <= state == ST_HOLD;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      hold_ok  <= 1'b0;
      hold_ffo <= 32'h0;
    end else if (state == ST_TRACK && !loss_of_lock_flag) begin
      hold_ok  <= 1'b1;
      hold_ffo <= ffo_clamp;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      dco_ffo_o <= 32'h0;
      phase_rep <= 32'h0;
    end else begin
      phase_rep <= loop_phase_i;
      case (state)
        ST_TRACK: dco_ffo_o <= ffo_clamp;
        ST_HOLD:  dco_ffo_o <= hold_ffo;
        default:  dco_ffo_o <= 32'h0;
      endcase
    end
  end

  assign ms_tick = tick_cnt == 32'(TICK_CYCLES - 1);
  assign to_hit  = state == ST_TRACK && loss_of_lock_flag && lk_timeout != 16'h0 && to_cnt == lk_timeout && sel != REF_NONE;
  assign lock_timeout_flag_set = to_hit ? 3'(3'b001 << (sel - 2'h1)) : 3'b000;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || ms_tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // restarts whenever the attempt restarts: new reference, lock, or leaving tracking
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || state != ST_TRACK || !loss_of_lock_flag || next_sel != sel || to_hit) begin
      to_cnt <= 16'h0;
    end else if (ms_tick && to_cnt != lk_timeout) begin
      to_cnt <= to_cnt + 16'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      lock_timeout_flag <= 3'b000;
    end else begin
      lock_timeout_flag <= (lock_timeout_flag & ~lock_timeout_flag_clr) | lock_timeout_flag_set;
    end
  end

  // axi4-lite write: address and data taken in either order
  assign axi_o = '{awready: !aw_full && !b_vld, wready: !w_full && !b_vld, bresp: b_rsp, bvalid: b_vld,
                   arready: !r_vld, rdata: r_dat, rresp: r_rsp, rvalid: r_vld};
  assign do_write      = aw_full && w_full && !b_vld;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      b_vld        <= 1'b0;
      b_rsp        <= RESP_OKAY;
    end else begin
      if (axi_i.awvalid && axi_o.awready) begin
        aw_full <= 1'b1;
        aw_addr <= axi_i.awaddr;
      end
      if (axi_i.wvalid && axi_o.wready) begin
        w_full <= 1'b1;
        w_data <= axi_i.wdata;
        w_strb <= axi_i.wstrb;
      end
      if (do_write) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        b_vld        <= 1'b1;
        b_rsp        <= (aw_addr > OFS_NOMINAL_HI || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (b_vld && axi_i.bready) begin
        b_vld        <= 1'b0;
      end
    end
  end

  assign lock_timeout_flag_clr = (do_write && aw_addr == OFS_INPUT_STATUS && w_strb[0]) ? w_data[2:0] : 3'b000;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      {revertive_enable_en, pin_sw_en}            <= 2'b00;
      prio                              <= PRIO_RST;
      sw_pin_sel                        <= 2'h0;
      {freq_crit, hold_beh, mode}       <= {2'b00, MODE_AUTO};
      range_ppm                         <= RANGE_MAX_PPM;
      lk_timeout                        <= 16'h0;
      stage_lo                          <= NOMINAL[31:0];
      stage_hi                          <= NOMINAL[39:32];
      nco_pend                          <= 2'b00;
      nco_word_o                        <= NOMINAL;
    end else begin
      if (nco_pend == 2'b11) begin
        nco_word_o <= {stage_hi, stage_lo};
        nco_pend   <= 2'b00;
      end
      if (do_write) begin
        case (aw_addr)
          OFS_REF_SELECT_CONTROL: {revertive_enable_en, pin_sw_en} <= 2'(wr32({30'h0, revertive_enable_en, pin_sw_en}, w_data, w_strb));
          OFS_INPUT_PRIORITY_REG: prio <= 12'(wr32({20'h0, prio}, w_data, w_strb));
          OFS_MISC_CONTROL_TWO:   sw_pin_sel <= 2'(wr32({30'h0, sw_pin_sel}, w_data, w_strb));
          OFS_PLL_CONTROL_ONE:    {freq_crit, hold_beh, mode} <= 4'(wr32({28'h0, freq_crit, hold_beh, mode}, w_data, w_strb));
          OFS_TRACK_RANGE: begin
            // out-of-range settings snap to the nearest legal range
            if (wr32({22'h0, range_ppm}, w_data, w_strb) > {22'h0, RANGE_MAX_PPM}) begin
              range_ppm <= RANGE_MAX_PPM;
            end else if (wr32({22'h0, range_ppm}, w_data, w_strb) < {22'h0, RANGE_MIN_PPM}) begin
              range_ppm <= RANGE_MIN_PPM;
            end else begin
              range_ppm <= 10'(wr32({22'h0, range_ppm}, w_data, w_strb));
            end
          end
          OFS_PHASE_LOCK_TIMEOUT: lk_timeout <= 16'(wr32({16'h0, lk_timeout}, w_data, w_strb));
          OFS_NCO_WORD_LO: begin
            stage_lo    <= wr32(stage_lo, w_data, w_strb);
            nco_pend[0] <= 1'b1;
          end
          OFS_NCO_WORD_HI: begin
            stage_hi    <= 8'(wr32({24'h0, stage_hi}, w_data, w_strb));
            nco_pend[1] <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0;
    case (axi_i.araddr)
      OFS_REF_SELECT_CONTROL: rd_data = {30'h0, revertive_enable_en, pin_sw_en};
      OFS_INPUT_PRIORITY_REG: rd_data = {20'h0, prio};
      OFS_MISC_CONTROL_TWO:   rd_data = {30'h0, sw_pin_sel};
      OFS_PRIORITY_TABLE_TOP: rd_data = {26'h0, top_ref, 2'h0, sel};
      OFS_PLL_CONTROL_ONE:    rd_data = {28'h0, freq_crit, hold_beh, mode};
      OFS_PLL_STATE_STATUS:   rd_data = {29'h0, holdover, loss_of_lock_flag, tracking};
      OFS_PLL_STATE_STATUS2:  rd_data = {31'h0, range_lim};
      OFS_TRACK_RANGE:        rd_data = {22'h0, range_ppm};
      OFS_PHASE_LOCK_TIMEOUT: rd_data = {16'h0, lk_timeout};
      OFS_INPUT_STATUS:       rd_data = {25'h0, ref_valid_i, 1'b0, lock_timeout_flag};
      OFS_FREQUENCY_REPORT:   rd_data = dco_ffo_o;
      OFS_PHASE_REPORT:       rd_data = phase_rep;
      OFS_NCO_WORD_LO:        rd_data = nco_word_o[31:0];
      OFS_NCO_WORD_HI:        rd_data = {24'h0, nco_word_o[39:32]};
      OFS_NOMINAL_LO:         rd_data = NOMINAL[31:0];
      OFS_NOMINAL_HI:         rd_data = {24'h0, NOMINAL[39:32]};
      default:                rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r_vld <= 1'b0;
      r_dat <= 32'h0;
      r_rsp <= RESP_OKAY;
    end else if (axi_i.arvalid && axi_o.arready) begin
      r_vld <= 1'b1;
      r_dat <= rd_data;
      r_rsp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_vld && axi_i.rready) begin
      r_vld <= 1'b0;
    end
  end

  assign sel_ref_o   = sel;
  assign open_loop_o = !tracking;
  assign nco_mode_o  = state == ST_NCO;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_pin_high;
    pin_sw_en && pin_lvl;
  endsequence
  property p_ext_one;
    s_pin_high and (prio[3:0] != PRIO_OFF) |=> sel == REF_ONE;
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("pin high did not pick input one");
  property p_ext_three;
    s_pin_high and (prio[3:0] == PRIO_OFF) |=> sel == REF_THREE;
  endproperty
  a_ext_three: assert property (p_ext_three) else $error("pin high did not pick input three");
  property p_ext_two;
    pin_sw_en && !pin_lvl |=> sel == REF_TWO;
  endproperty
  a_ext_two: assert property (p_ext_two) else $error("pin low did not pick input two");
  property p_auto_prio;
    !pin_sw_en && top_ref != REF_NONE && (revertive_enable_en || !sel_ok) |=> sel == $past(top_ref);
  endproperty
  a_auto_prio: assert property (p_auto_prio) else $error("automatic selection missed top input");
  property p_open;
    !pin_sw_en && mode == MODE_AUTO && top_ref == REF_NONE |=> ##1 !tracking;
  endproperty
  a_open: assert property (p_open) else $error("tracking with no valid input");
  property p_freerun;
    state == ST_FREERUN |=> dco_ffo_o == 32'h0;
  endproperty
  a_freerun: assert property (p_freerun) else $error("freerun offset not zero");
  property p_hold;
    state == ST_HOLD && $stable(hold_ffo) |=> dco_ffo_o == $past(hold_ffo);
  endproperty
  a_hold: assert property (p_hold) else $error("hold offset not kept");
  property p_nco_whole;
    $changed(nco_word_o) |-> $past(nco_pend) == 2'b11;
  endproperty
  a_nco_whole: assert property (p_nco_whole) else $error("partial nco word applied");
  property p_lock_timeout_flag;
    to_hit |=> lock_timeout_flag[$past(sel) - 2'h1];
  endproperty
  a_lock_timeout_flag: assert property (p_lock_timeout_flag) else $error("lock timeout flag not set");
  property p_range;
    state == ST_TRACK && at_limit |=> range_lim && (dco_ffo_o == $past(lim) || dco_ffo_o == 32'(-$signed($past(lim))));
  endproperty
  a_range: assert property (p_range) else $error("range limit not flagged or clamped");
endmodule : drsc_dpll_ctrl

// >>> drsc_ref_model.sv
// far-side model: monitor verdicts, switch pins and loop measurements
`timescale 1ns/100ps
module drsc_ref_model (
  input  wire logic        ref_clk_i,     // master clock
  input  wire logic [2:0]  valid_i,       // wanted input validity
  input  wire logic [3:0]  pin_i,         // wanted pin levels
  input  wire logic        lock_i,        // wanted phase lock verdict
  input  wire logic [31:0] ffo_i,         // wanted loop offset
  input  wire logic [31:0] phase_i,       // wanted phase
  output logic [2:0]       ref_valid_o,   // to design validity
  output logic [3:0]       gpio_o,        // to design pins
  output logic             phase_ok_o,    // to design lock verdict
  output logic [31:0]      loop_ffo_o,    // to design offset
  output logic [31:0]      loop_phase_o   // to design phase
);
  // launched on the rising edge like the real monitors
  always_ff @(posedge ref_clk_i) begin
    ref_valid_o  <= valid_i;
    gpio_o       <= pin_i;
    phase_ok_o   <= lock_i;
    loop_ffo_o   <= ffo_i;
    loop_phase_o <= phase_i;
  end
endmodule : drsc_ref_model

// >>> drsc_dpll_ctrl_tb.sv
// register-level testbench of the dpll reference and state control block
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module drsc_dpll_ctrl_tb;
  import drsc_pkg::*;
  // +100 ppm of nominal, rounded; derived from the nominal word, not the previous one
  localparam logic [39:0] NCO_STEP = 40'h000346dc5d;
  localparam logic [39:0] NCO_NEW  = NOMINAL_DEF + NCO_STEP;
  logic           ref_clk_i;
  logic           sys_rst_i;
  drsc_axil_req_t req;
  drsc_axil_rsp_t rsp;
  logic [2:0]     valid, rv;
  logic [3:0]     pin, gp;
  logic           lock, pok, ol, nm;
  logic [31:0]    ffo, phase, lffo, lph, dco, rdat;
  logic [1:0]     sel, lr;
  logic [39:0]    word;
  int             error_cnt, comparisons;

  drsc_ref_model drsc_ref_model_i (.ref_clk_i(ref_clk_i), .valid_i(valid), .pin_i(pin), .lock_i(lock),
    .ffo_i(ffo), .phase_i(phase), .ref_valid_o(rv), .gpio_o(gp), .phase_ok_o(pok), .loop_ffo_o(lffo),
    .loop_phase_o(lph));
  drsc_dpll_ctrl #(.TICK_CYCLES(4)) drsc_dpll_ctrl_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .axi_i(req), .axi_o(rsp), .ref_valid_i(rv), .gpio_i(gp), .loop_phase_ok_i(pok), .loop_ffo_i(lffo),
    .loop_phase_i(lph), .sel_ref_o(sel), .open_loop_o(ol), .nco_mode_o(nm), .dco_ffo_o(dco),
    .nco_word_o(word));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic summarize;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic tmo;
    error_cnt++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  endtask : tmo

  // ready sampled mid-cycle: it is registered state, so it equals the value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw, w, done;
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    @(posedge ref_clk_i);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge ref_clk_i);
      done = !aw && !w && (rsp.bvalid === 1'b1);
      if (done) lr = rsp.bresp;
      if (aw && rsp.awready === 1'b1) aw = 1'b0;
      if (w && rsp.wready === 1'b1) w = 1'b0;
      @(posedge ref_clk_i);
      req.awvalid <= aw;
      req.wvalid <= w;
      req.bready <= !done;
    end
    if (!done) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int   n;
    logic ar, done;
    ar = 1'b1;
    done = 1'b0;
    @(posedge ref_clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge ref_clk_i);
      done = !ar && (rsp.rvalid === 1'b1);
      if (done) rdat = rsp.rdata;
      if (done) lr = rsp.rresp;
      if (ar && rsp.arready === 1'b1) ar = 1'b0;
      @(posedge ref_clk_i);
      req.arvalid <= ar;
      req.rready <= !done;
    end
    if (!done) tmo();
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdat, e)
  endtask : rdc

  // model register, pin sync and state pipeline all settle within this
  task automatic wt;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : wt

  initial begin
    int n;
    req = '0;
    sys_rst_i = 1'b1;
    {valid, pin, lock, ffo, phase} = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rdc(OFS_INPUT_PRIORITY_REG, 32'h00000321);
    rdc(OFS_TRACK_RANGE, 32'h000003e8);
    rdc(OFS_NOMINAL_LO, NOMINAL_DEF[31:0]);
    rdc(OFS_NOMINAL_HI, {24'h0, NOMINAL_DEF[39:32]});
    rdc(OFS_PLL_STATE_STATUS, 32'h00000002);
    rd(8'h40);
    `CHK(lr, RESP_SLVERR)
    wr(8'h40, 32'h1);
    `CHK(lr, RESP_SLVERR)
    wr(OFS_PHASE_LOCK_TIMEOUT, 32'h0);
    valid <= 3'b111;
    lock <= 1'b1;
    ffo <= 32'h00000100;
    phase <= 32'h00001234;
    wt();
    `CHK(sel, REF_ONE)
    `CHK(ol, 1'b0)
    rdc(OFS_PLL_STATE_STATUS, 32'h00000001);
    rdc(OFS_PHASE_REPORT, 32'h00001234);
    rdc(OFS_FREQUENCY_REPORT, 32'h00000100);
    lock <= 1'b0;
    wt();
    rdc(OFS_PLL_STATE_STATUS, 32'h00000003);
    wr(OFS_INPUT_PRIORITY_REG, 32'h320);
    wt();
    `CHK(sel, REF_TWO)
    wr(OFS_INPUT_PRIORITY_REG, 32'h123);
    wt();
    // nonrevertive: a better input waits until the revertive bit is set
    `CHK(sel, REF_TWO)
    wr(OFS_REF_SELECT_CONTROL, 32'h2);
    wt();
    `CHK(sel, REF_THREE)
    wr(OFS_REF_SELECT_CONTROL, 32'h0);
    wr(OFS_INPUT_PRIORITY_REG, 32'h321);
    lock <= 1'b1;
    wt();
    valid <= 3'b000;
    wt();
    `CHK(ol, 1'b1)
    rdc(OFS_PLL_STATE_STATUS, 32'h00000006);
    `CHK(dco, 32'h00000100)
    wr(OFS_PLL_CONTROL_ONE, 32'h4);
    wt();
    rdc(OFS_PLL_STATE_STATUS, 32'h00000002);
    `CHK(dco, 32'h00000000)
    wr(OFS_PLL_CONTROL_ONE, {30'h0, MODE_AUTO});
    valid <= 3'b111;
    wt();
    rdc(OFS_PLL_STATE_STATUS, 32'h00000001);
    wr(OFS_PLL_CONTROL_ONE, {30'h0, MODE_FORCE_OPEN});
    wt();
    `CHK(ol, 1'b1)
    wr(OFS_PLL_CONTROL_ONE, {30'h0, MODE_AUTO});
    wr(OFS_TRACK_RANGE, 32'h0);
    rdc(OFS_TRACK_RANGE, 32'h00000001);
    wr(OFS_TRACK_RANGE, 32'h7ff);
    rdc(OFS_TRACK_RANGE, 32'h000003e8);
    wr(OFS_TRACK_RANGE, {22'h0, RANGE_MIN_PPM});
    ffo <= UNITS_PER_PPM;
    wt();
    rdc(OFS_PLL_STATE_STATUS2, 32'h00000001);
    ffo <= 32'h00100000;
    wt();
    rdc(OFS_FREQUENCY_REPORT, UNITS_PER_PPM);
    wr(OFS_PLL_CONTROL_ONE, 32'h8);
    wt();
    rdc(OFS_PLL_STATE_STATUS, 32'h00000003);
    wr(OFS_PLL_CONTROL_ONE, 32'h0);
    wr(OFS_TRACK_RANGE, {22'h0, RANGE_MAX_PPM});
    // revertive bit set too: the pin mux must ignore it
    wr(OFS_MISC_CONTROL_TWO, 32'h2);
    pin <= 4'b0100;
    valid <= 3'b010;
    wr(OFS_REF_SELECT_CONTROL, 32'h3);
    wt();
    `CHK(sel, REF_ONE)
    rdc(OFS_PRIORITY_TABLE_TOP, 32'h00000021);
    pin <= 4'b1011;
    wt();
    `CHK(sel, REF_TWO)
    valid <= 3'b000;
    wt();
    `CHK(sel, REF_TWO)
    pin <= 4'b0100;
    wr(OFS_INPUT_PRIORITY_REG, 32'h320);
    wt();
    `CHK(sel, REF_THREE)
    wr(OFS_INPUT_PRIORITY_REG, 32'h321);
    wr(OFS_REF_SELECT_CONTROL, 32'h0);
    valid <= 3'b011;
    lock <= 1'b0;
    wt();
    `CHK(sel, REF_ONE)
    wr(OFS_PHASE_LOCK_TIMEOUT, 32'h2);
    for (n = 0; n < 100 && sel === REF_ONE; n++) @(negedge ref_clk_i);
    if (n == 100) tmo();
    lock <= 1'b1;
    wt();
    `CHK(sel, REF_TWO)
    rdc(OFS_INPUT_STATUS, 32'h00000031);
    wr(OFS_PHASE_LOCK_TIMEOUT, 32'h0);
    wr(OFS_INPUT_STATUS, 32'h1);
    rdc(OFS_INPUT_STATUS, 32'h00000030);
    wr(OFS_PLL_CONTROL_ONE, {30'h0, MODE_NCO});
    wt();
    `CHK(nm, 1'b1)
    wr(OFS_NCO_WORD_LO, NCO_NEW[31:0]);
    wt();
    `CHK(word, NOMINAL_DEF)
    wr(OFS_NCO_WORD_HI, {24'h0, NCO_NEW[39:32]});
    wt();
    `CHK(word, NCO_NEW)
    rdc(OFS_NCO_WORD_LO, NCO_NEW[31:0]);
    summarize();
  end
endmodule : drsc_dpll_ctrl_tb
